// ===== verilog/hsl_defs.vh
// constants of the serial line unit
// assumes the controller's 8-bit port is synchronous to clk_sys and the link pins are asynchronous to it
// Operation
// - serial bits are gathered directly into one 16-bit word, with no byte stage in between.
// - the received 16-bit word is read by the controller as a low and a high byte.
// - the controller writes two transmit bytes and the unit shifts them out onto the link.
// - each link bit travels under a four-way handshake, both directions at once, no bit clock.
// - link status from the far node is read over the same port as the received bytes.
// - the controller port is full duplex and 8 bits wide.
// - buffer transfers are governed by a 14-bit word count and an 18-bit bus address.
// - up to 8 transmit and 8 receive buffer descriptors may wait in a chain.
// - completion and faults set status flags and then raise an attention output to the host.
// - a final partial word is sent or received, its end marked by the final-bit enable on send and the last line on receive.
// - received bytes are read at the two receive byte registers and status at two others.
`ifndef HSL_DEFS_VH
`define HSL_DEFS_VH
// ----------------------------------------------------------------
// port register indices
// ----------------------------------------------------------------
`define HSL_R_TX_LO     5'h10
`define HSL_R_TX_HI     5'h11
`define HSL_R_TX_CTL    5'h12
`define HSL_R_LINE_STAT 5'h13
`define HSL_R_RX_LO     5'h14
`define HSL_R_RX_HI     5'h15
`define HSL_R_RX_CTL    5'h16
`define HSL_R_RX_STAT   5'h17
// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define HSL_B_FINAL_EN     6
`define HSL_B_FAULT_CLR    3
`define HSL_B_SEND_CLR     2
`define HSL_B_HOST_RDY     3
`define HSL_B_RECV_CLR     2
`define HSL_B_FETCH        2
// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define HSL_WORD_W   16
`define HSL_FIFO_D   8
`define HSL_FIFO_AW  3
`define HSL_DESC_W   32
`define HSL_ADDR_W   18
`define HSL_CNT_W    14
`define HSL_ADDR_INC 18'h00002
`define HSL_CTL_RST  8'h00
`endif

// ===== verilog/hsl_fifo.v
// parameterised fifo, valid/ready on both sides
// assumes one clock; reads the head combinationally from the array
`timescale 1ns/1ps
module hsl_fifo #(
	parameter W  = 16,
	parameter D  = 8,
	parameter AW = 3
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         arst_n,
	// fill side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg  [W-1:0] mem [0:D-1];
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	reg  [AW:0]   fill;
	wire          do_wr;
	wire          do_rd;

	assign in_ready  = (fill != D[AW:0]);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	always @(posedge clk_sys) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				fill <= fill + 1'b1;
			end else if (do_rd && !do_wr) begin
				fill <= fill - 1'b1;
			end
		end
	end
endmodule

// ===== verilog/hsl_line_unit.v
// line unit: 8-bit controller port, four-way handshake serial link, chain bookkeeping
// assumes link pins are asynchronous to clk_sys; controller port is synchronous
`timescale 1ns/1ps
`include "hsl_defs.vh"
module hsl_line_unit (
	// clock and reset
	input  wire                   clk_sys,
	input  wire                   arst_n,
	// controller data port
	input  wire [4:0]             port_addr,
	input  wire                   port_wr,
	input  wire                   port_rd,
	input  wire [7:0]             port_wdata,
	output reg  [7:0]             port_rdata,
	// link, transmit direction
	output reg                    tx_bit,
	output reg                    tx_there,
	output reg                    tx_last,
	input  wire                   tx_ack_in,
	// link, receive direction
	input  wire                   rx_bit_in,
	input  wire                   rx_there_in,
	input  wire                   rx_last_in,
	output reg                    rx_ack,
	// link readiness
	input  wire                   far_ready_in,
	output reg                    host_ready,
	// buffer descriptors
	input  wire                   desc_push,
	input  wire                   desc_is_rx,
	input  wire [`HSL_ADDR_W-1:0] desc_addr,
	input  wire [`HSL_CNT_W-1:0]  desc_count,
	output reg                    tx_queue_full,
	output reg                    rx_queue_full,
	output reg  [`HSL_ADDR_W-1:0] tx_dma_addr,
	output reg  [`HSL_ADDR_W-1:0] rx_dma_addr,
	// host attention
	output reg                    tx_done,
	output reg                    rx_done,
	output reg                    host_attention
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [4:0] sync_a;
	reg [4:0] sync_b;
	wire      s_tx_ack    = sync_b[0];
	wire      s_rx_bit    = sync_b[1];
	wire      s_rx_there  = sync_b[2];
	wire      s_rx_last   = sync_b[3];
	wire      s_far_ready = sync_b[4];

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
		end else begin
			sync_a <= {far_ready_in, rx_last_in, rx_there_in, rx_bit_in, tx_ack_in};
			sync_b <= sync_a;
		end
	end

	// ----------------------------------------------------------------
	// port decode
	// ----------------------------------------------------------------
	// byte wide port strobes
	wire wr_tx_lo  = port_wr && (port_addr == `HSL_R_TX_LO);
	wire wr_tx_hi  = port_wr && (port_addr == `HSL_R_TX_HI);
	wire wr_tx_ctl = port_wr && (port_addr == `HSL_R_TX_CTL);
	wire wr_rx_ctl = port_wr && (port_addr == `HSL_R_RX_CTL);
	wire wr_rx_st  = port_wr && (port_addr == `HSL_R_RX_STAT);
	wire clr_fault = wr_tx_ctl && port_wdata[`HSL_B_FAULT_CLR];
	wire clr_send  = wr_tx_ctl && port_wdata[`HSL_B_SEND_CLR];
	wire clr_recv  = wr_rx_ctl && port_wdata[`HSL_B_RECV_CLR];
	wire fetch     = wr_rx_st && port_wdata[`HSL_B_FETCH];

	reg [7:0] tx_lo;
	reg       final_en;

	// ----------------------------------------------------------------
	// transmit serialiser
	// ----------------------------------------------------------------
	localparam TX_IDLE = 4'b0001;
	localparam TX_SET  = 4'b0010;
	localparam TX_WAIT = 4'b0100;
	localparam TX_DROP = 4'b1000;

	reg [3:0]             tx_state;
	reg [`HSL_WORD_W-1:0] tx_shift;
	reg [3:0]             tx_idx;
	reg [3:0]             tx_end;
	reg                   tx_fault;
	reg                   tx_word_sent;
	wire                  tx_start = wr_tx_hi && (tx_state == TX_IDLE);

	// last bit of a final word is its highest set bit
	function [3:0] top_one;
		input [`HSL_WORD_W-1:0] w;
		integer i;
		begin
			top_one = 4'h0;
			for (i = 0; i < `HSL_WORD_W; i = i + 1) begin
				if (w[i]) begin
					top_one = i[3:0];
				end
			end
		end
	endfunction

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_state     <= TX_IDLE;
			tx_shift     <= 16'h0000;
			tx_idx       <= 4'h0;
			tx_end       <= 4'hf;
			tx_bit       <= 1'b0;
			tx_there     <= 1'b0;
			tx_last      <= 1'b0;
			tx_fault     <= 1'b0;
			tx_word_sent <= 1'b0;
		end else begin
			tx_word_sent <= 1'b0;
			case (tx_state)
			TX_IDLE: begin
				// two bytes handed over, shifted low byte first
				if (tx_start) begin
					tx_shift <= {port_wdata, tx_lo};
					tx_idx   <= 4'h0;
					tx_end   <= final_en ? top_one({port_wdata, tx_lo}) : 4'hf;
					tx_state <= TX_SET;
				end
			end
			TX_SET: begin
				// data settles one cycle before the strobe is raised
				tx_bit   <= tx_shift[0];
				tx_last  <= final_en && (tx_idx == tx_end);
				tx_state <= TX_WAIT;
			end
			TX_WAIT: begin
				// strobe high until the far end acknowledges
				tx_there <= 1'b1;
				if (tx_there && s_tx_ack) begin
					tx_there <= 1'b0;
					tx_state <= TX_DROP;
				end
			end
			TX_DROP: begin
				// wait for acknowledge to fall before the next bit
				if (!s_tx_ack) begin
					tx_shift <= {1'b0, tx_shift[`HSL_WORD_W-1:1]};
					tx_idx   <= tx_idx + 1'b1;
					if (tx_idx == tx_end) begin
						tx_last      <= 1'b0;
						tx_word_sent <= 1'b1;
						tx_state     <= TX_IDLE;
					end else begin
						tx_state <= TX_SET;
					end
				end
			end
			default: begin
				tx_state <= TX_IDLE;
			end
			endcase
			if ((wr_tx_hi && !tx_start) || (!s_far_ready && tx_state != TX_IDLE)) begin
				tx_fault <= 1'b1;
			end else if (clr_fault) begin
				tx_fault <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive assembler
	// ----------------------------------------------------------------
	localparam RX_WAIT = 2'b01;
	localparam RX_HOLD = 2'b10;

	reg [1:0]             rx_state;
	reg [`HSL_WORD_W-1:0] rx_shift;
	reg [3:0]             rx_idx;
	reg                   rx_push;
	reg [`HSL_WORD_W:0]   rx_push_data;
	reg                   rx_fault;
	reg                   in_message;
	wire                  rxf_ready;
	wire                  rxf_valid;
	wire [`HSL_WORD_W:0]  rxf_data;
	wire [`HSL_WORD_W-1:0] rx_next = rx_shift | ({{(`HSL_WORD_W-1){1'b0}}, s_rx_bit} << rx_idx);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_state     <= RX_WAIT;
			rx_shift     <= 16'h0000;
			rx_idx       <= 4'h0;
			rx_ack       <= 1'b0;
			rx_push      <= 1'b0;
			rx_push_data <= 17'h00000;
			rx_fault     <= 1'b0;
			in_message   <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			case (rx_state)
			RX_WAIT: begin
				// bits are taken only when the buffer can hold a finished word
				if (s_rx_there && rxf_ready && host_ready) begin
					rx_ack     <= 1'b1;
					in_message <= !s_rx_last;
					rx_state   <= RX_HOLD;
					// sixteen bits or a final bit close the word
					if (s_rx_last || rx_idx == 4'hf) begin
						rx_push      <= 1'b1;
						rx_push_data <= {s_rx_last, rx_next};
						rx_shift     <= 16'h0000;
						rx_idx       <= 4'h0;
					end else begin
						rx_shift <= rx_next;
						rx_idx   <= rx_idx + 1'b1;
					end
				end
			end
			RX_HOLD: begin
				// acknowledge stays up until the strobe falls
				if (!s_rx_there) begin
					rx_ack   <= 1'b0;
					rx_state <= RX_WAIT;
				end
			end
			default: begin
				rx_state <= RX_WAIT;
			end
			endcase
			// far node loss wins over clear
			if (in_message && !s_far_ready) begin
				rx_fault <= 1'b1;
			end else if (clr_recv) begin
				rx_fault <= 1'b0;
			end
		end
	end

	// finished words wait here and are read as two bytes
	hsl_fifo #(
		.W  (`HSL_WORD_W + 1),
		.D  (`HSL_FIFO_D),
		.AW (`HSL_FIFO_AW)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (rx_push),
		.in_ready  (rxf_ready),
		.in_data   (rx_push_data),
		.out_valid (rxf_valid),
		.out_ready (fetch),
		.out_data  (rxf_data)
	);

	// ----------------------------------------------------------------
	// buffer descriptor chains
	// ----------------------------------------------------------------
	wire                   tq_in_ready;
	wire                   tq_valid;
	wire [`HSL_DESC_W-1:0] tq_data;
	wire                   rq_in_ready;
	wire                   rq_valid;
	wire [`HSL_DESC_W-1:0] rq_data;
	reg                    tx_act;
	reg                    rx_act;
	reg  [`HSL_CNT_W-1:0]  tx_cnt;
	reg  [`HSL_CNT_W-1:0]  rx_cnt;
	wire                   tq_pop = !tx_act && tq_valid;
	wire                   rq_pop = !rx_act && rq_valid;
	wire                   tx_fin = tx_act && (tx_cnt == 14'h0000 || (tx_start && tx_cnt == 14'h0001));
	wire                   rx_fin = rx_act && (rx_cnt == 14'h0000 ||
	                                           (fetch && rxf_valid && rx_cnt == 14'h0001));

	hsl_fifo #(
		.W  (`HSL_DESC_W),
		.D  (`HSL_FIFO_D),
		.AW (`HSL_FIFO_AW)
	) u_tx_desc (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (desc_push && !desc_is_rx),
		.in_ready  (tq_in_ready),
		.in_data   ({desc_count, desc_addr}),
		.out_valid (tq_valid),
		.out_ready (tq_pop),
		.out_data  (tq_data)
	);

	hsl_fifo #(
		.W  (`HSL_DESC_W),
		.D  (`HSL_FIFO_D),
		.AW (`HSL_FIFO_AW)
	) u_rx_desc (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (desc_push && desc_is_rx),
		.in_ready  (rq_in_ready),
		.in_data   ({desc_count, desc_addr}),
		.out_valid (rq_valid),
		.out_ready (rq_pop),
		.out_data  (rq_data)
	);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_act         <= 1'b0;
			rx_act         <= 1'b0;
			tx_cnt         <= 14'h0000;
			rx_cnt         <= 14'h0000;
			tx_dma_addr    <= 18'h00000;
			rx_dma_addr    <= 18'h00000;
			tx_done        <= 1'b0;
			rx_done        <= 1'b0;
			host_attention <= 1'b0;
			tx_queue_full  <= 1'b0;
			rx_queue_full  <= 1'b0;
		end else begin
			// flags lag one cycle; a push into a full queue is lost
			tx_queue_full <= !tq_in_ready;
			rx_queue_full <= !rq_in_ready;
			// load count and address, step per word moved
			if (tq_pop) begin
				tx_act      <= 1'b1;
				tx_cnt      <= tq_data[`HSL_DESC_W-1:`HSL_ADDR_W];
				tx_dma_addr <= tq_data[`HSL_ADDR_W-1:0];
			end else if (tx_fin) begin
				tx_act <= 1'b0;
			end else if (tx_act && tx_start) begin
				tx_cnt      <= tx_cnt - 1'b1;
				tx_dma_addr <= tx_dma_addr + `HSL_ADDR_INC;
			end
			if (rq_pop) begin
				rx_act      <= 1'b1;
				rx_cnt      <= rq_data[`HSL_DESC_W-1:`HSL_ADDR_W];
				rx_dma_addr <= rq_data[`HSL_ADDR_W-1:0];
			end else if (rx_fin) begin
				rx_act <= 1'b0;
			end else if (rx_act && fetch && rxf_valid) begin
				rx_cnt      <= rx_cnt - 1'b1;
				rx_dma_addr <= rx_dma_addr + `HSL_ADDR_INC;
			end
			// sticky completion flags, set wins over clear
			if (tx_fin) begin
				tx_done <= 1'b1;
			end else if (clr_send) begin
				tx_done <= 1'b0;
			end
			if (rx_fin) begin
				rx_done <= 1'b1;
			end else if (clr_recv) begin
				rx_done <= 1'b0;
			end
			host_attention <= tx_done | rx_done | tx_fault | rx_fault;
		end
	end

	// ----------------------------------------------------------------
	// port registers and read data
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_lo      <= `HSL_CTL_RST;
			final_en   <= 1'b0;
			host_ready <= 1'b0;
			port_rdata <= 8'h00;
		end else begin
			if (wr_tx_lo) begin
				tx_lo <= port_wdata;
			end
			if (wr_tx_ctl) begin
				final_en <= port_wdata[`HSL_B_FINAL_EN];
			end
			if (wr_rx_ctl) begin
				host_ready <= port_wdata[`HSL_B_HOST_RDY];
			end
			if (port_rd) begin
				case (port_addr)
				`HSL_R_TX_CTL: begin
					port_rdata <= {1'b0, final_en, 6'h00};
				end
				// far node status on the data port
				`HSL_R_LINE_STAT: begin
					port_rdata <= {1'b0, !s_far_ready, 2'b00, !s_tx_ack,
					               tx_state == TX_IDLE, tx_done, tx_fault};
				end
				// received word as low and high byte
				`HSL_R_RX_LO: begin
					port_rdata <= rxf_valid ? rxf_data[7:0] : 8'h00;
				end
				`HSL_R_RX_HI: begin
					port_rdata <= rxf_valid ? rxf_data[15:8] : 8'h00;
				end
				`HSL_R_RX_CTL: begin
					port_rdata <= {4'h0, host_ready, 3'b000};
				end
				`HSL_R_RX_STAT: begin
					port_rdata <= {1'b0, rx_fault, 2'b00, rxf_valid && rxf_data[16],
					               rxf_valid, rx_done, 1'b0};
				end
				default: begin
					port_rdata <= 8'h00;
				end
				endcase
			end
		end
	end
endmodule

// ===== testbench/hsl_props_properties.sv
// checker: port reads and link handshake
// assumes binding to hsl_line_unit ports
`timescale 1ns/1ps
module hsl_props (
	// clock and reset
	input wire       clk_sys,
	input wire       arst_n,
	// controller port
	input wire [4:0] port_addr,
	input wire       port_wr,
	input wire       port_rd,
	input wire [7:0] port_wdata,
	input wire [7:0] port_rdata,
	// link
	input wire       tx_bit,
	input wire       tx_there,
	input wire       tx_last,
	input wire       tx_ack_in,
	input wire       rx_there_in,
	input wire       rx_ack,
	input wire       host_ready,
	// attention
	input wire       tx_done,
	input wire       rx_done,
	input wire       host_attention
);
	// ----------------------------------------------------------------
	// sequences and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// ack is synchronised, hence a window
	sequence s_ack_seen;
		tx_there && $rose(tx_ack_in);
	endsequence
	sequence s_there_gone;
		!rx_there_in [*5];
	endsequence
	property p_unmapped_rd;
		port_rd && !port_addr[4] |=> port_rdata == 8'h00;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
	property p_rdata_hold;
		!port_rd |=> $stable(port_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_host_ready;
		port_wr && port_addr == 5'h16 |=> host_ready == $past(port_wdata[3]);
	endproperty
	a_host_ready: assert property (p_host_ready) else $error("host ready not stored");
	property p_there_hold;
		tx_there && !tx_ack_in |=> tx_there;
	endproperty
	a_there_hold: assert property (p_there_hold) else $error("strobe dropped early");
	property p_bit_stable;
		tx_there ##1 tx_there |-> $stable(tx_bit) && $stable(tx_last);
	endproperty
	a_bit_stable: assert property (p_bit_stable) else $error("bit moved under strobe");
	property p_there_drop;
		s_ack_seen |-> ##[1:4] !tx_there;
	endproperty
	a_there_drop: assert property (p_there_drop) else $error("strobe not released");
	property p_no_restrobe;
		!tx_there && tx_ack_in |=> !tx_there;
	endproperty
	a_no_restrobe: assert property (p_no_restrobe) else $error("strobe while ack high");
	property p_rx_ack_cause;
		$rose(rx_ack) |-> $past(rx_there_in, 2) && host_ready;
	endproperty
	a_rx_ack_cause: assert property (p_rx_ack_cause) else $error("ack without strobe");
	property p_rx_ack_drop;
		s_there_gone |-> !rx_ack;
	endproperty
	a_rx_ack_drop: assert property (p_rx_ack_drop) else $error("ack held too long");
	property p_attention;
		tx_done || rx_done |=> host_attention;
	endproperty
	a_attention: assert property (p_attention) else $error("attention missing");
endmodule
bind hsl_line_unit hsl_props i_hsl_props (
	.clk_sys(clk_sys), .arst_n(arst_n), .port_addr(port_addr), .port_wr(port_wr),
	.port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata), .tx_bit(tx_bit),
	.tx_there(tx_there), .tx_last(tx_last), .tx_ack_in(tx_ack_in), .rx_there_in(rx_there_in),
	.rx_ack(rx_ack), .host_ready(host_ready), .tx_done(tx_done), .rx_done(rx_done),
	.host_attention(host_attention)
);

// ===== testbench/hsl_far_node.sv
// far node model, both link directions
// assumes clk_sys paces it; dly slows its acknowledge
`timescale 1ns/1ps
module hsl_far_node (
	// clock
	input wire  clk_sys,
	// from the unit
	input wire  tx_bit,
	input wire  tx_there,
	input wire  tx_last,
	output reg  tx_ack_in,
	// to the unit
	output reg  rx_bit_in,
	output reg  rx_there_in,
	output reg  rx_last_in,
	input wire  rx_ack,
	// readiness
	output reg  far_ready_in
);
	integer    dly, got_n, sent_n, t;
	reg [15:0] got_word;
	reg        got_last;
	initial begin
		tx_ack_in = 1'b0;
		rx_bit_in = 1'b0;
		rx_there_in = 1'b0;
		rx_last_in = 1'b0;
		far_ready_in = 1'b1;
		dly = 0;
		got_n = 0;
		sent_n = 0;
	end
	// take bit, ack, await strobe low
	always begin
		@(posedge clk_sys);
		#1;
		if (tx_there === 1'b1) begin
			repeat (dly) begin
				@(posedge clk_sys);
				#1;
			end
			got_word[got_n[3:0]] = tx_bit;
			got_last = tx_last;
			got_n = got_n + 1;
			tx_ack_in = 1'b1;
			while (tx_there !== 1'b0) begin
				@(posedge clk_sys);
				#1;
			end
			tx_ack_in = 1'b0;
		end
	end
	// bit0 first, held until ack; released lines inverted
	task send(input [15:0] w, input integer n, input lst);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(posedge clk_sys);
				#1;
				rx_bit_in = w[i];
				rx_last_in = lst && (i == n - 1);
				@(posedge clk_sys);
				#1;
				rx_there_in = 1'b1;
				t = 0;
				while (rx_ack !== 1'b1 && t < 5000) begin
					@(posedge clk_sys);
					#1;
					t = t + 1;
				end
				rx_there_in = 1'b0;
				rx_bit_in = ~rx_bit_in;
				rx_last_in = ~rx_last_in;
				while (rx_ack !== 1'b0 && t < 5000) begin
					@(posedge clk_sys);
					#1;
					t = t + 1;
				end
			end
			sent_n = sent_n + 1;
		end
	endtask
endmodule

// ===== testbench/tb.sv
// bench: port, descriptors, far node
// assumes the bound checker; one task per scenario
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	reg         clk_sys;
	reg         arst_n;
	reg  [4:0]  port_addr;
	reg         port_wr;
	reg         port_rd;
	reg  [7:0]  port_wdata;
	reg         desc_push;
	reg         desc_is_rx;
	reg  [17:0] desc_addr;
	reg  [13:0] desc_count;
	reg  [7:0]  d;
	wire [7:0]  port_rdata;
	wire [17:0] tx_dma_addr;
	wire [17:0] rx_dma_addr;
	wire        tx_bit, tx_there, tx_last, tx_ack_in, rx_bit_in, rx_there_in, rx_last_in;
	wire        rx_ack, far_ready_in, host_ready, tx_queue_full, rx_queue_full;
	wire        tx_done, rx_done, host_attention;
	integer     err_count, num_checks, cyc, t, k, j, base;
	hsl_line_unit i_hsl_line_unit (
		.clk_sys(clk_sys), .arst_n(arst_n), .port_addr(port_addr), .port_wr(port_wr),
		.port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata), .tx_bit(tx_bit),
		.tx_there(tx_there), .tx_last(tx_last), .tx_ack_in(tx_ack_in), .rx_bit_in(rx_bit_in),
		.rx_there_in(rx_there_in), .rx_last_in(rx_last_in), .rx_ack(rx_ack),
		.far_ready_in(far_ready_in), .host_ready(host_ready), .desc_push(desc_push),
		.desc_is_rx(desc_is_rx), .desc_addr(desc_addr), .desc_count(desc_count),
		.tx_queue_full(tx_queue_full), .rx_queue_full(rx_queue_full),
		.tx_dma_addr(tx_dma_addr), .rx_dma_addr(rx_dma_addr), .tx_done(tx_done),
		.rx_done(rx_done), .host_attention(host_attention)
	);
	hsl_far_node i_hsl_far_node (
		.clk_sys(clk_sys), .tx_bit(tx_bit), .tx_there(tx_there), .tx_last(tx_last),
		.tx_ack_in(tx_ack_in), .rx_bit_in(rx_bit_in), .rx_there_in(rx_there_in),
		.rx_last_in(rx_last_in), .rx_ack(rx_ack), .far_ready_in(far_ready_in)
	);
	// ----------------------------------------------------------------
	// port tasks
	// ----------------------------------------------------------------
	task chk(input [8*12:1] name, input [17:0] seen, input [17:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task wr(input [4:0] a, input [7:0] v);
		begin
			@(posedge clk_sys);
			#1;
			port_addr = a;
			port_wdata = v;
			port_wr = 1'b1;
			@(posedge clk_sys);
			#1;
			port_wr = 1'b0;
		end
	endtask
	task rd(input [4:0] a);
		begin
			@(posedge clk_sys);
			#1;
			port_addr = a;
			port_rd = 1'b1;
			@(posedge clk_sys);
			#1;
			port_rd = 1'b0;
			d = port_rdata;
		end
	endtask
	task rchk(input [4:0] a, input [7:0] e);
		begin
			rd(a);
			chk("port_rdata", d, e);
		end
	endtask
	task push(input rx, input [17:0] a, input [13:0] n);
		begin
			@(posedge clk_sys);
			#1;
			desc_is_rx = rx;
			desc_addr = a;
			desc_count = n;
			desc_push = 1'b1;
			@(posedge clk_sys);
			#1;
			desc_push = 1'b0;
		end
	endtask
	// polls status bit2
	task wait_bit(input [4:0] a);
		begin
			t = 0;
			d = 8'h00;
			while (d[2] !== 1'b1 && t < 3000) begin
				rd(a);
				t = t + 1;
			end
		end
	endtask
	task wait_tx(input integer n);
		begin
			t = 0;
			while (i_hsl_far_node.got_n < n && t < 3000) begin
				@(posedge clk_sys);
				t = t + 1;
			end
			wait_bit(5'h13);
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		begin
			rchk(5'h13, 8'h0c);
			rchk(5'h17, 8'h00);
			rchk(5'h12, 8'h00);
			rchk(5'h16, 8'h00);
			rchk(5'h05, 8'h00);
			chk("queue_full", {tx_queue_full, rx_queue_full}, 2'b00);
			$display("t_reset done");
		end
	endtask
	task t_tx_words;
		begin
			push(1'b0, 18'h00100, 14'h0002);
			i_hsl_far_node.got_n = 0;
			wr(5'h10, 8'ha5);
			wr(5'h11, 8'h3c);
			wait_tx(16);
			chk("tx_word", i_hsl_far_node.got_word, 16'h3ca5);
			chk("tx_last", i_hsl_far_node.got_last, 1'b0);
			chk("tx_dma_addr", tx_dma_addr, 18'h00102);
			i_hsl_far_node.dly = 3;
			i_hsl_far_node.got_n = 0;
			wr(5'h10, 8'h5a);
			wr(5'h11, 8'hc3);
			wr(5'h11, 8'hff);
			wait_tx(16);
			chk("tx_word", i_hsl_far_node.got_word, 16'hc35a);
			chk("tx_bits", i_hsl_far_node.got_n, 16);
			rchk(5'h13, 8'h0f);
			chk("tx_done", tx_done, 1'b1);
			chk("attention", host_attention, 1'b1);
			wr(5'h12, 8'h0c);
			rchk(5'h13, 8'h0c);
			chk("attention", host_attention, 1'b0);
			i_hsl_far_node.dly = 0;
			$display("t_tx_words done");
		end
	endtask
	task t_tx_final;
		begin
			wr(5'h12, 8'h40);
			rchk(5'h12, 8'h40);
			i_hsl_far_node.got_n = 0;
			wr(5'h10, 8'h05);
			wr(5'h11, 8'h00);
			wait_tx(3);
			chk("tx_bits", i_hsl_far_node.got_n, 3);
			chk("tx_word", i_hsl_far_node.got_word[2:0], 3'b101);
			chk("tx_last", i_hsl_far_node.got_last, 1'b1);
			wr(5'h12, 8'h00);
			$display("t_tx_final done");
		end
	endtask
	task t_rx_word;
		begin
			push(1'b1, 18'h00200, 14'h0001);
			wr(5'h16, 8'h08);
			i_hsl_far_node.send(16'hbeef, 16, 1'b0);
			wait_bit(5'h17);
			rchk(5'h14, 8'hef);
			rchk(5'h15, 8'hbe);
			rchk(5'h17, 8'h04);
			wr(5'h17, 8'h04);
			rchk(5'h17, 8'h02);
			chk("rx_dma_addr", rx_dma_addr, 18'h00200);
			wr(5'h16, 8'h0c);
			rchk(5'h17, 8'h00);
			$display("t_rx_word done");
		end
	endtask
	// a full buffer holds back the ninth word
	task t_rx_fill;
		begin
			base = i_hsl_far_node.sent_n;
			fork
				begin
					for (j = 0; j < 8; j = j + 1)
						i_hsl_far_node.send({8'ha0 + j[7:0], 8'h50 + j[7:0]}, 16, 1'b0);
					i_hsl_far_node.send(16'h000a, 4, 1'b1);
				end
			join_none
			t = 0;
			while (i_hsl_far_node.sent_n < base + 8 && t < 3000) begin
				@(posedge clk_sys);
				t = t + 1;
			end
			repeat (20) @(posedge clk_sys);
			chk("rx_ack", rx_ack, 1'b0);
			for (k = 0; k < 8; k = k + 1) begin
				rchk(5'h14, 8'h50 + k);
				rchk(5'h15, 8'ha0 + k);
				wr(5'h17, 8'h04);
			end
			wait_bit(5'h17);
			rchk(5'h14, 8'h0a);
			rchk(5'h15, 8'h00);
			rd(5'h17);
			chk("msg_final", d[3], 1'b1);
			wr(5'h17, 8'h04);
			$display("t_rx_fill done");
		end
	endtask
	task t_link_fault;
		begin
			i_hsl_far_node.send(16'h0003, 3, 1'b0);
			i_hsl_far_node.far_ready_in = 1'b0;
			repeat (4) @(posedge clk_sys);
			rd(5'h17);
			chk("link_fault", d[6], 1'b1);
			rd(5'h13);
			chk("not_ready", d[6], 1'b1);
			chk("attention", host_attention, 1'b1);
			i_hsl_far_node.far_ready_in = 1'b1;
			repeat (4) @(posedge clk_sys);
			wr(5'h16, 8'h0c);
			rd(5'h17);
			chk("link_fault", d[6], 1'b0);
			$display("t_link_fault done");
		end
	endtask
	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task conclude;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			err_count = err_count + 1;
			conclude;
		end
	end
	initial begin
		err_count = 0;
		num_checks = 0;
		cyc = 0;
		arst_n = 1'b0;
		port_addr = 5'h00;
		port_wr = 1'b0;
		port_rd = 1'b0;
		port_wdata = 8'h00;
		desc_push = 1'b0;
		desc_is_rx = 1'b0;
		desc_addr = 18'h00000;
		desc_count = 14'h0000;
		repeat (5) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset;
		t_tx_words;
		t_tx_final;
		t_rx_word;
		t_rx_fill;
		t_link_fault;
		conclude;
	end
endmodule
